// *** verilog/link_pkg.sv ***
// Function
// - wrong parity sets receive error, clears start, sets done together
// - after a parity error the acknowledge still follows the stop bit
// - missing stop bit: keep clocking until a stop bit arrives, then acknowledge
// - first missing stop bit sets receive error at once; done sets and start clears later
// - receive error interrupts only while its enable bit is set
// - clock held low during transmission aborts, never an error
// - data held low during transmission aborts and sets host request and abort
// - lines stuck high are ignored, no error or abort
// - any error or abort returns the data register to zero
// - wait mode leaves the port running; its flags request a wake only while their enable bits are set
// - halt freezes the port and all registers; its events cannot end halt
// - four flags, each gated by its enable, share one interrupt line
// - control enables at bits 6..3, bit 7 reserved and zero
// - start bit: set by data write in transmit, or by software in receive after a host request; software clear aborts transmit only
// - direction bit 0 transmit, 1 receive; writable only while start is clear
// - enable bit switches the port off or on
// - frequency field picks cpu clock ratio; writable only while port is off
// - timing-off bit disables timeouts; writable only while port is off
// - status flags set by hardware, cleared by writing one
// - an abort sets the abort flag and leaves done clear
// - data write when idle in transmit sets start and begins transmission
// - data register reads zero while a transfer is in progress
// - frame is start, eight data bits, odd parity and stop
// - link clock is made here with an 80 us period from the cpu clock
// - with timing on, 100 us gaps before transmit and before receive
package link_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] CTL_IDX0  = 8'h4e;
	localparam logic [7:0] CSR_IDX0  = 8'h4f;
	localparam logic [7:0] DATA_IDX0 = 8'h50;
	localparam logic [7:0] CTL_IDX1  = 8'h51;
	localparam logic [7:0] CSR_IDX1  = 8'h52;
	localparam logic [7:0] DATA_IDX1 = 8'h53;
	localparam logic [7:0] REG_RESET = 8'h00;
	// control bit positions
	localparam int CTL_RXE_EN  = 6;
	localparam int CTL_HRQ_EN  = 5;
	localparam int CTL_ABT_EN  = 4;
	localparam int CTL_DONE_EN = 3;
	localparam int CTL_START   = 2;
	localparam int CTL_DIR     = 1;
	localparam int CTL_ON      = 0;
	// config/status bit positions
	localparam int CSR_CPU_FREQ_SELECT_HI = 6;
	localparam int CSR_CPU_FREQ_SELECT_LO = 5;
	localparam int CSR_TIMING_OFF_BIT    = 4;
	localparam int CSR_RXE     = 3;
	localparam int CSR_HRQ     = 2;
	localparam int CSR_ABT     = 1;
	localparam int CSR_DONE    = 0;
	// timing
	localparam int TICK_NS      = 2500;
	localparam int HALF_NS      = 40000;
	localparam int TIMEOUT_NS   = 100000;
	localparam int HALF_TICKS   = HALF_NS / TICK_NS;
	localparam int TIMEOUT_TICKS = TIMEOUT_NS / TICK_NS;
	localparam int MHZ_SEL0 = 12;
	localparam int MHZ_SEL1 = 8;
	localparam int MHZ_SEL2 = 6;
	localparam int MHZ_SEL3 = 4;
	// frame layout
	localparam int RX_PAR_BIT  = 8;
	localparam int RX_STOP_BIT = 9;
	localparam int TX_LAST_BIT = 10;
	typedef enum logic [2:0] {
		st_off, st_idle, st_rx_ready, st_tx, st_rx, st_ack
	} state_type;
endpackage

// *** verilog/host_link_error_regs.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_link_error_regs #(
	parameter int PORT_INDEX = 0,
	parameter int ADDR_W     = 12
) (
	// clock and reset
	input  wire logic              clock,
	input  wire logic              srst,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// cpu rate and power
	input  wire logic              cpu_ce,
	input  wire logic              cpu_halt,
	output logic                   irq,
	output logic                   wake_request,
	// link lines
	input  wire logic              link_clock_line_in,
	output logic                   link_clock_line_out,
	output logic                   link_clock_line_oe_n,
	input  wire logic              link_data_line_in,
	output logic                   link_data_line_out,
	output logic                   link_data_line_oe_n
);
	localparam logic [7:0] CTL_IDX  = (PORT_INDEX == 0) ?
		link_pkg::CTL_IDX0 : link_pkg::CTL_IDX1;
	localparam logic [7:0] CSR_IDX  = (PORT_INDEX == 0) ?
		link_pkg::CSR_IDX0 : link_pkg::CSR_IDX1;
	localparam logic [7:0] DATA_IDX = (PORT_INDEX == 0) ?
		link_pkg::DATA_IDX0 : link_pkg::DATA_IDX1;
	localparam logic [4:0] HALF_LAST = 5'(link_pkg::HALF_TICKS - 1);
	localparam logic [5:0] GAP_FULL  = 6'(link_pkg::TIMEOUT_TICKS);

	logic            clk_m_q, clk_s_q, dat_m_q, dat_s_q;
	logic            run;
	logic [4:0]      presc_q, ratio;
	logic            tick, half_end;
	logic [4:0]      hc_q;
	logic            phase_q;
	logic [3:0]      bit_q, bit_d;
	logic [10:0]     frame_q;
	logic            perr_q, perr_d, serr_q, serr_d;
	logic [5:0]      gap_q;
	logic            gap_done;
	link_pkg::state_type state_q, state_d;
	logic [3:0]      en_q;
	logic            start_q, dir_q, on_q;
	logic [1:0]      cpu_freq_select_q;
	logic            timing_off_bit_q;
	logic [3:0]      flag_q, flag_set;
	logic [7:0]      data_q;
	logic            ev_start_clr, ev_clear_data, ev_load_data, ev_load_tx;
	logic            ev_abort, ev_sample;
	logic            acc, wr, aligned;
	logic [ADDR_W-3:0] idx;
	logic            hit_ctl, hit_csr, hit_data;
	logic            in_frame, tx_bit, drive_clk, drive_dat;
	logic            clk_oe_n_q, dat_oe_n_q, irq_q;

	// line synchronisers
	always_ff @(posedge clock) begin
		if (srst) begin
			clk_m_q <= 1'b1;
			clk_s_q <= 1'b1;
			dat_m_q <= 1'b1;
			dat_s_q <= 1'b1;
		end else begin
			clk_m_q <= link_clock_line_in;
			clk_s_q <= clk_m_q;
			dat_m_q <= link_data_line_in;
			dat_s_q <= dat_m_q;
		end
	end

	assign run = ~cpu_halt;

	// 2.5 us tick from the cpu rate
	always_comb begin
		case (cpu_freq_select_q)
			2'b00:   ratio = 5'(link_pkg::MHZ_SEL0 * link_pkg::TICK_NS / 1000);
			2'b01:   ratio = 5'(link_pkg::MHZ_SEL1 * link_pkg::TICK_NS / 1000);
			2'b10:   ratio = 5'(link_pkg::MHZ_SEL2 * link_pkg::TICK_NS / 1000);
			default: ratio = 5'(link_pkg::MHZ_SEL3 * link_pkg::TICK_NS / 1000);
		endcase
	end
	assign tick = run & on_q & cpu_ce & (presc_q == ratio - 5'd1);
	always_ff @(posedge clock) begin
		if (srst || !on_q) begin
			presc_q <= 5'd0;
		end else if (run && cpu_ce) begin
			presc_q <= tick ? 5'd0 : presc_q + 5'd1;
		end
	end

	// bus decode
	assign acc      = psel & penable;
	assign wr       = acc & pwrite & run;
	assign idx      = paddr[ADDR_W-1:2];
	assign aligned  = (paddr[1:0] == 2'b00);
	assign hit_ctl  = aligned & (idx == (ADDR_W-2)'(CTL_IDX));
	assign hit_csr  = aligned & (idx == (ADDR_W-2)'(CSR_IDX));
	assign hit_data = aligned & (idx == (ADDR_W-2)'(DATA_IDX));
	assign pready   = 1'b1;
	assign pslverr  = acc & ~(hit_ctl | hit_csr | hit_data);
	always_comb begin
		prdata = 32'h0;
		if (hit_ctl) begin
			prdata[7:0] = {1'b0, en_q, start_q, dir_q, on_q};
		end else if (hit_csr) begin
			prdata[7:0] = {1'b0, cpu_freq_select_q, timing_off_bit_q, flag_q};
		end else if (hit_data) begin
			prdata[7:0] = start_q ? 8'h00 : data_q;
		end
	end

	// bit clock engine
	assign in_frame = (state_q == link_pkg::st_tx) |
		(state_q == link_pkg::st_rx) | (state_q == link_pkg::st_ack);
	assign half_end = tick & (hc_q == HALF_LAST);
	assign tx_bit   = frame_q[bit_q];
	assign gap_done = timing_off_bit_q | (gap_q == GAP_FULL);

	always_comb begin
		state_d       = state_q;
		bit_d         = bit_q;
		perr_d        = perr_q;
		serr_d        = serr_q;
		flag_set      = 4'h0;
		ev_start_clr  = 1'b0;
		ev_clear_data = 1'b0;
		ev_load_data  = 1'b0;
		ev_load_tx    = 1'b0;
		ev_abort      = 1'b0;
		ev_sample     = 1'b0;
		case (state_q)
			link_pkg::st_off: begin
				if (on_q) begin
					state_d = link_pkg::st_idle;
				end
			end
			link_pkg::st_idle: begin
				if (clk_s_q && !dat_s_q) begin
					flag_set[link_pkg::CSR_HRQ] = 1'b1;
					state_d = link_pkg::st_rx_ready;
				end else if (clk_s_q && start_q && !dir_q && gap_done) begin
					ev_load_tx = 1'b1;
					state_d = link_pkg::st_tx;
					bit_d = 4'd0;
				end
			end
			link_pkg::st_rx_ready: begin
				if (start_q && dir_q && gap_done) begin
					state_d = link_pkg::st_rx;
					bit_d = 4'd0;
					perr_d = 1'b0;
					serr_d = 1'b0;
				end
			end
			link_pkg::st_tx: begin
				if (!start_q) begin
					ev_abort = 1'b1;
				end else if (half_end && !phase_q) begin
					if (!clk_s_q) begin
						ev_abort = 1'b1;
					end else if (tx_bit && !dat_s_q) begin
						ev_abort = 1'b1;
						flag_set[link_pkg::CSR_HRQ] = 1'b1;
					end
				end else if (half_end && phase_q) begin
					if (bit_q == 4'(link_pkg::TX_LAST_BIT)) begin
						flag_set[link_pkg::CSR_DONE] = 1'b1;
						ev_start_clr = 1'b1;
						state_d = link_pkg::st_idle;
					end else begin
						bit_d = bit_q + 4'd1;
					end
				end
			end
			link_pkg::st_rx: begin
				if (half_end && !phase_q && !clk_s_q) begin
					ev_abort = 1'b1;
				end else if (half_end && phase_q) begin
					// sample late in the low half, host data settled
					ev_sample = 1'b1;
					if (bit_q == 4'(link_pkg::RX_PAR_BIT) &&
						!(^{frame_q[7:0], dat_s_q})) begin
						perr_d = 1'b1;
						flag_set[link_pkg::CSR_RXE] = 1'b1;
						flag_set[link_pkg::CSR_DONE] = 1'b1;
						ev_start_clr = 1'b1;
						ev_clear_data = 1'b1;
					end
					if (bit_q == 4'(link_pkg::RX_STOP_BIT) && !dat_s_q &&
						!serr_q) begin
						serr_d = 1'b1;
						flag_set[link_pkg::CSR_RXE] = 1'b1;
					end
					if (bit_q != 4'(link_pkg::RX_STOP_BIT)) begin
						bit_d = bit_q + 4'd1;
					end else if (dat_s_q) begin
						state_d = link_pkg::st_ack;
					end
				end
			end
			link_pkg::st_ack: begin
				if (half_end && phase_q) begin
					state_d = link_pkg::st_idle;
					if (!perr_q) begin
						flag_set[link_pkg::CSR_DONE] = 1'b1;
						ev_start_clr = 1'b1;
						ev_load_data = !serr_q;
						ev_clear_data = serr_q;
					end
				end
			end
			default: state_d = link_pkg::st_off;
		endcase
		if (ev_abort) begin
			flag_set[link_pkg::CSR_ABT] = 1'b1;
			ev_start_clr = 1'b1;
			ev_clear_data = 1'b1;
			state_d = link_pkg::st_idle;
		end
		if (!on_q) begin
			state_d = link_pkg::st_off;
			ev_start_clr = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_q <= link_pkg::st_off;
			bit_q   <= 4'd0;
			perr_q  <= 1'b0;
			serr_q  <= 1'b0;
		end else if (run) begin
			state_q <= state_d;
			bit_q   <= bit_d;
			perr_q  <= perr_d;
			serr_q  <= serr_d;
		end
	end

	// half period counter and clock phase
	always_ff @(posedge clock) begin
		if (srst || !in_frame) begin
			hc_q    <= 5'd0;
			phase_q <= 1'b0;
		end else if (tick) begin
			hc_q    <= half_end ? 5'd0 : hc_q + 5'd1;
			phase_q <= half_end ? ~phase_q : phase_q;
		end
	end

	// frame shift store
	always_ff @(posedge clock) begin
		if (srst) begin
			frame_q <= 11'h0;
		end else if (run && ev_load_tx) begin
			frame_q <= {1'b1, ~(^data_q), data_q, 1'b0};
		end else if (run && ev_sample) begin
			frame_q[bit_q] <= dat_s_q;
		end
	end

	// inter-frame and response gap
	always_ff @(posedge clock) begin
		if (srst || in_frame || !clk_s_q ||
			(state_q == link_pkg::st_idle && !dat_s_q)) begin
			gap_q <= 6'd0;
		end else if (tick && gap_q != GAP_FULL) begin
			gap_q <= gap_q + 6'd1;
		end
	end

	// control register
	always_ff @(posedge clock) begin
		if (srst) begin
			en_q  <= link_pkg::REG_RESET[3:0];
			dir_q <= 1'b0;
			on_q  <= 1'b0;
		end else if (wr && hit_ctl) begin
			en_q <= pwdata[link_pkg::CTL_RXE_EN:link_pkg::CTL_DONE_EN];
			on_q <= pwdata[link_pkg::CTL_ON];
			if (!start_q) begin
				dir_q <= pwdata[link_pkg::CTL_DIR];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			start_q <= 1'b0;
		end else if (run) begin
			if (ev_start_clr) begin
				start_q <= 1'b0;
			end else if (wr && hit_data && !start_q && !dir_q && on_q) begin
				start_q <= 1'b1;
			end else if (wr && hit_ctl) begin
				if (pwdata[link_pkg::CTL_START]) begin
					start_q <= start_q |
						(dir_q & (state_q == link_pkg::st_rx_ready));
				end else if (state_q != link_pkg::st_rx &&
					state_q != link_pkg::st_ack) begin
					start_q <= 1'b0;
				end
			end
		end
	end

	// config and flags
	always_ff @(posedge clock) begin
		if (srst) begin
			cpu_freq_select_q <= 2'b00;
			timing_off_bit_q <= 1'b0;
		end else if (wr && hit_csr && !on_q) begin
			cpu_freq_select_q <= pwdata[link_pkg::CSR_CPU_FREQ_SELECT_HI:link_pkg::CSR_CPU_FREQ_SELECT_LO];
			timing_off_bit_q <= pwdata[link_pkg::CSR_TIMING_OFF_BIT];
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			flag_q <= link_pkg::REG_RESET[3:0];
		end else if (run) begin
			flag_q <= (flag_q & ~((wr && hit_csr) ?
				pwdata[link_pkg::CSR_RXE:link_pkg::CSR_DONE] : 4'h0)) |
				flag_set;
		end
	end

	// data register
	always_ff @(posedge clock) begin
		if (srst) begin
			data_q <= link_pkg::REG_RESET;
		end else if (run) begin
			if (ev_clear_data) begin
				data_q <= link_pkg::REG_RESET;
			end else if (ev_load_data) begin
				data_q <= frame_q[7:0];
			end else if (wr && hit_data && !start_q && !dir_q && on_q) begin
				data_q <= pwdata[7:0];
			end
		end
	end

	// open drain drivers and interrupt
	assign drive_clk = in_frame & phase_q;
	assign drive_dat = ((state_q == link_pkg::st_tx) & ~tx_bit) |
		(state_q == link_pkg::st_ack);
	always_ff @(posedge clock) begin
		if (srst) begin
			clk_oe_n_q <= 1'b1;
			dat_oe_n_q <= 1'b1;
			irq_q      <= 1'b0;
		end else begin
			clk_oe_n_q <= ~drive_clk;
			dat_oe_n_q <= ~drive_dat;
			irq_q      <= |(flag_q & en_q);
		end
	end
	assign link_clock_line_out  = 1'b0;
	assign link_data_line_out   = 1'b0;
	assign link_clock_line_oe_n = clk_oe_n_q;
	assign link_data_line_oe_n  = dat_oe_n_q;
	assign irq                  = irq_q;
	assign wake_request         = irq_q;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	property p_parity_end;
		(run && state_q == link_pkg::st_rx && perr_d && !perr_q && !ev_abort)
		|=> (flag_q[link_pkg::CSR_RXE] && flag_q[link_pkg::CSR_DONE] &&
		!start_q && data_q == 8'h00);
	endproperty
	a_parity_end: assert property (p_parity_end)
		else $error("parity error did not end reception");

	property p_abort_flags;
		(run && ev_abort && on_q) |=> (flag_q[link_pkg::CSR_ABT] && !start_q &&
		data_q == 8'h00 && state_q == link_pkg::st_idle);
	endproperty
	a_abort_flags: assert property (p_abort_flags)
		else $error("abort did not clear start and data");

	property p_abort_no_done;
		(run && ev_abort && !flag_q[link_pkg::CSR_DONE])
		|=> !flag_q[link_pkg::CSR_DONE];
	endproperty
	a_abort_no_done: assert property (p_abort_no_done)
		else $error("abort set the done flag");

	property p_high_no_abort;
		(state_q == link_pkg::st_tx && start_q && on_q && clk_s_q && dat_s_q)
		|-> !ev_abort;
	endproperty
	a_high_no_abort: assert property (p_high_no_abort)
		else $error("lines high caused an abort");

	property p_irq_gate;
		(flag_q[link_pkg::CSR_RXE] && !en_q[3] &&
		(flag_q[2:0] & en_q[2:0]) == 3'b000) |=> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("receive error interrupt without enable");

	property p_irq_any;
		(|(flag_q & en_q)) ##1 (|(flag_q & en_q)) |-> irq && wake_request;
	endproperty
	a_irq_any: assert property (p_irq_any)
		else $error("enabled flag not on interrupt line");

	property p_halt_frozen;
		(cpu_halt && !srst) |=> ($stable(data_q) && $stable(flag_q) &&
		$stable(start_q));
	endproperty
	a_halt_frozen: assert property (p_halt_frozen)
		else $error("register changed during halt");

	property p_read_zero;
		(psel && !pwrite && hit_data && start_q) |-> prdata == 32'h0;
	endproperty
	a_read_zero: assert property (p_read_zero)
		else $error("data read nonzero during transfer");

	property p_dir_locked;
		(wr && hit_ctl && start_q) |=> $stable(dir_q);
	endproperty
	a_dir_locked: assert property (p_dir_locked)
		else $error("direction changed while started");

	property p_cfg_locked;
		(wr && hit_csr && on_q) |=> ($stable(cpu_freq_select_q) && $stable(timing_off_bit_q));
	endproperty
	a_cfg_locked: assert property (p_cfg_locked)
		else $error("config changed while port on");
endmodule
`default_nettype wire

// *** test/link_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
	// resolved link lines
	input  wire logic clk_line,
	input  wire logic data_line,
	// open-drain pulls, high = pull low
	output logic      clk_low,
	output logic      data_low
);
	initial begin
		clk_low = 1'b0;
		data_low = 1'b0;
	end
	// sample each device bit at clock fall
	task automatic recv(output logic [10:0] f);
		for (int i = 0; i < 11; i++) begin
			@(negedge clk_line);
			f[i] = data_line;
		end
	endtask
	// abort only by pulling clock or data low
	task automatic pull(input logic ck, input int edges);
		repeat (edges) @(negedge clk_line);
		if (ck) clk_low = 1'b1;
		else data_low = 1'b1;
	endtask
	task automatic let_go();
		clk_low = 1'b0;
		data_low = 1'b0;
	endtask
	// start bit is the request; bits change after clock fall
	task automatic send(input logic [7:0] b, input logic bad_par,
			input logic bad_stop, output logic ack);
		logic [9:0] bits;
		bits = {~bad_stop, ~^b ^ bad_par, b};
		data_low = 1'b1;
		for (int i = 0; i < 10; i++) begin
			@(negedge clk_line);
			data_low = ~bits[i];
		end
		if (bad_stop) begin
			@(negedge clk_line);
			data_low = 1'b0;
		end
		@(negedge clk_line);
		#50;
		ack = (data_line === 1'b0);
	endtask
endmodule
`default_nettype wire

// *** test/host_link_error_regs_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module host_link_error_regs_bench;
	localparam int CTL = 4 * link_pkg::CTL_IDX0;
	localparam int CSR = 4 * link_pkg::CSR_IDX0;
	localparam int DAT = 4 * link_pkg::DATA_IDX0;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic        cpu_ce = 1'b1;
	logic        cpu_halt = 1'b0;
	logic [31:0] prdata;
	logic        pready, pslverr, irq, wake_request;
	logic        ck_oe_n, dt_oe_n, host_ck, host_dt;
	wire logic   clk_line = ck_oe_n & ~host_ck;
	wire logic   data_line = dt_oe_n & ~host_dt;
	int          n_mismatch = 0;
	int          checked = 0;
	int          k;
	logic        last_err, ack;
	logic [7:0]  rd, b;
	logic [10:0] f;
	logic [7:0]  q[$];
	logic [7:0]  ctl_rx [3] = '{8'h3b, 8'h03, 8'h43};

	always #2.5 clock = ~clock;

	host_link_error_regs #(.PORT_INDEX(0), .ADDR_W(12)) dut (
		.clock(clock), .srst(srst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_ce(cpu_ce), .cpu_halt(cpu_halt), .irq(irq),
		.wake_request(wake_request),
		.link_clock_line_in(clk_line), .link_clock_line_out(),
		.link_clock_line_oe_n(ck_oe_n),
		.link_data_line_in(data_line), .link_data_line_out(),
		.link_data_line_oe_n(dt_oe_n)
	);
	link_host_model host (
		.clk_line(clk_line), .data_line(data_line),
		.clk_low(host_ck), .data_low(host_dt)
	);

	task automatic chk(input string what, input logic [15:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input int a, input logic [7:0] wd);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a[11:0];
		pwdata <= {24'h0, wd};
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rd = prdata[7:0];
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input int a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input string what, input int a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(what, {8'h00, rd}, {8'h00, e});
	endtask
	task automatic wait_csr(input logic [7:0] m);
		do begin
			apb(1'b0, CSR, 8'h00);
		end while ((rd & m) !== m);
	endtask
	task automatic irqc(input logic e);
		chk("irq", {15'h0, irq}, {15'h0, e});
		chk("wake", {15'h0, wake_request}, {15'h0, e});
	endtask
	task automatic done_t(input string s);
		$display("test %s finished", s);
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_mismatch++;
		$display("watchdog expired");
		tally_and_finish();
	end

	initial begin
		void'($urandom(50));
		repeat (16) @(posedge clock);
		srst <= 1'b0;
		for (k = 0; k < 3; k++) begin
			rdc("reset value", CTL + 4 * k, link_pkg::REG_RESET);
			chk("mapped", {15'h0, last_err}, 16'h0000);
		end
		apb(1'b0, 0, 8'h00);
		chk("unmapped", {15'h0, last_err}, 16'h0001);
		chk("idle lines", {14'h0, ck_oe_n, dt_oe_n}, 16'h0003);
		irqc(1'b0);
		done_t("reset");
		wr(DAT, 8'h5a);
		rdc("ctl off", CTL, 8'h00);
		wr(CSR, 8'hf0);
		rdc("csr timing", CSR, 8'h70);
		wr(CSR, 8'he0);
		rdc("csr freq", CSR, 8'h60);
		wr(CTL, 8'hb9);
		rdc("ctl on", CTL, 8'h39);
		wr(CSR, 8'h10);
		rdc("csr locked", CSR, 8'h60);
		done_t("config");
		b = 8'($urandom);
		q.push_back(b);
		wr(DAT, b);
		rdc("start set", CTL, 8'h3d);
		rdc("busy data", DAT, 8'h00);
		wr(CTL, 8'h3f);
		rdc("dir locked", CTL, 8'h3d);
		host.recv(f);
		b = q.pop_front();
		chk("frame", {5'h00, f}, {5'h00, 1'b1, ~^b, b, 1'b0});
		wait_csr(8'h01);
		chk("tx flags", {8'h00, rd}, 16'h0061);
		rdc("start clear", CTL, 8'h39);
		irqc(1'b1);
		wr(CSR, 8'h00);
		rdc("write zero", CSR, 8'h61);
		wr(CSR, 8'h0f);
		rdc("cleared", CSR, 8'h60);
		irqc(1'b0);
		done_t("transmit");
		for (k = 0; k < 3; k++) begin
			b = 8'($urandom);
			wr(DAT, b);
			if (k == 1) begin
				repeat (3) @(negedge clk_line);
				wr(CTL, 8'h39);
			end else begin
				host.pull(k == 0, 3);
			end
			wait_csr(8'h02);
			chk("abort flags", {8'h00, rd}, (k == 2) ? 16'h0066 : 16'h0062);
			rdc("abort ctl", CTL, 8'h39);
			rdc("abort data", DAT, 8'h00);
			irqc(1'b1);
			if (k == 0) host.let_go();
			wr(CSR, 8'h0f);
		end
		done_t("abort");
		for (k = 0; k < 3; k++) begin
			if (k > 0) begin
				host.pull(1'b0, 0);
				wait_csr(8'h04);
				wr(CSR, 8'h0f);
			end
			b = 8'($urandom);
			wr(CTL, ctl_rx[k]);
			wr(CTL, ctl_rx[k] | 8'h04);
			if (k == 2) begin
				fork
					host.send(b, 1'b0, 1'b1, ack);
					begin
						repeat (11) @(negedge clk_line);
						rdc("stop early", CSR, 8'h68);
					end
				join
			end else begin
				host.send(b, k == 1, 1'b0, ack);
			end
			chk("ack", {15'h0, ack}, 16'h0001);
			wait_csr(8'h01);
			chk("rx flags", {8'h00, rd}, (k == 0) ? 16'h0061 : 16'h0069);
			rdc("rx ctl", CTL, ctl_rx[k]);
			rdc("rx data", DAT, (k == 0) ? b : 8'h00);
			irqc(k != 1);
			if (k == 1) begin
				wr(CTL, 8'h43);
				// irq is registered one edge behind the enable
				repeat (2) @(posedge clock);
				irqc(1'b1);
			end
			wr(CSR, 8'h0f);
		end
		done_t("receive");
		@(posedge clock);
		cpu_halt <= 1'b1;
		wr(CTL, 8'h00);
		rdc("halt ctl", CTL, 8'h43);
		@(posedge clock);
		cpu_halt <= 1'b0;
		wr(CTL, 8'h00);
		rdc("ctl off", CTL, 8'h00);
		done_t("halt");
		tally_and_finish();
	end
endmodule
`default_nettype wire
